// *** rucc_pkg.sv ***
// Package: register map, fields, encodings and timing for the update controller
//
// Contract
// - Remote mode power-up loads the image at page 000.
// - Factory logic writes the next application page into the control register.
// - Factory logic chooses watchdog enable and timeout for the next application.
// - Only remote-update application images can restart the watchdog.
// - Watchdog timeout records its cause in status then reloads factory.
// - Watchdog is disabled whenever the factory image is active.
// - Application load failure records its cause then loads factory automatically.
// - After fallback, factory reads status then writes the next page.
// - A clean application load enters user mode and runs it.
// - Application writes new image data then triggers a factory reload.
// - Page selection supports up to seven application pages.
// - Serial, parallel synchronous and parallel asynchronous loading are all supported.
// - Local update mode loads the single application directly at power-up.
package rucc_pkg;
    // Register byte offsets
    localparam logic [7:0] RUCC_CTRL_OFS   = 8'h00;
    localparam logic [7:0] RUCC_WDOG_OFS   = 8'h04;
    localparam logic [7:0] RUCC_CMD_OFS    = 8'h08;
    localparam logic [7:0] RUCC_STATE_OFS  = 8'h0c;
    localparam logic [7:0] RUCC_CAUSE_OFS  = 8'h10;
    localparam logic [7:0] RUCC_ISTAT_OFS  = 8'h14;
    localparam logic [7:0] RUCC_IMASK_OFS  = 8'h18;
    // Control fields
    localparam int RUCC_CTRL_PAGE_LSB = 0;
    localparam int RUCC_CTRL_WDEN_BIT = 4;
    localparam int RUCC_CTRL_LOC_BIT  = 5;
    localparam int RUCC_CTRL_SCH_LSB  = 8;
    // Command bits
    localparam int RUCC_CMD_RECFG_BIT = 0;
    localparam int RUCC_CMD_KICK_BIT  = 1;
    // Interrupt bits
    localparam int RUCC_IRQ_WDOG = 0;
    localparam int RUCC_IRQ_LERR = 1;
    localparam int RUCC_IRQ_USER = 2;
    localparam int RUCC_IRQ_N    = 3;
    // Pages
    localparam logic [2:0] RUCC_FACTORY_PAGE = 3'h0;
    localparam logic [2:0] RUCC_MAX_APP_PAGE = 3'h7;
    // Reset values
    localparam logic [31:0] RUCC_WDOG_RST = 32'h0000_0000;
    localparam logic [31:0] RUCC_CTRL_RST = 32'h0000_0000;
    // Load timeout: time in us and cycles at the clock rate
    localparam int RUCC_CLK_MHZ        = 25;
    localparam int RUCC_LOAD_TMO_US    = 1000;
    localparam int RUCC_LOAD_TMO_CYC   = RUCC_LOAD_TMO_US * RUCC_CLK_MHZ;
    // AXI responses
    localparam logic [1:0] RUCC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RUCC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        RUCC_CAUSE_NONE,
        RUCC_CAUSE_WDOG,
        RUCC_CAUSE_LERR,
        RUCC_CAUSE_USER
    } rucc_cause_e;

    typedef enum logic [1:0] {
        RUCC_SCH_SERIAL,
        RUCC_SCH_PSYNC,
        RUCC_SCH_PASYNC
    } rucc_sch_e;
endpackage

// *** rucc_ctrl.sv ***
// Remote/local update configuration controller with AXI4-Lite registers
module rucc_ctrl #(
    parameter int unsigned LOAD_TMO = rucc_pkg::RUCC_LOAD_TMO_CYC
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Mode strap and configuration memory side
    input  wire logic        local_mode_pin,
    input  wire logic        load_done_pin,
    input  wire logic        load_err_pin,
    output logic             load_start,
    output logic [2:0]       load_page,
    output logic [1:0]       load_scheme,
    // Status
    output logic             user_mode,
    output logic             factory_active,
    output logic             irq
);
    import rucc_pkg::*;

    typedef enum logic [1:0] {RUCC_ST_BOOT, RUCC_ST_LOAD, RUCC_ST_USER} rucc_st_e;

    rucc_st_e    st_q;
    rucc_cause_e cause_q;
    logic [31:0] ctrl_q, wdog_q, wcnt_q;
    logic [31:0] tmo_q;
    logic [RUCC_IRQ_N-1:0] istat_q, imask_q;
    logic        app_rupd_q;
    logic [1:0]  mode_s, done_s, err_s;
    logic        loc_q;
    logic        aw_q, w_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] n,
                                          input logic [3:0]  s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
        end
        return r;
    endfunction

    // Pin synchronisers
    always_ff @(posedge clock) begin
        mode_s <= {mode_s[0], local_mode_pin};
        done_s <= {done_s[0], load_done_pin};
        err_s  <= {err_s[0], load_err_pin};
    end

    // Write channel capture; address and data may come in either order
    logic wr_go, wr_ctrl, wr_wdog, wr_cmd, wr_imask, wr_hit;
    logic [31:0] cmd_w;
    assign wr_go    = aw_q && w_q && !s_axi_bvalid;
    assign wr_ctrl  = wr_go && awaddr_q == RUCC_CTRL_OFS;
    assign wr_wdog  = wr_go && awaddr_q == RUCC_WDOG_OFS;
    assign wr_cmd   = wr_go && awaddr_q == RUCC_CMD_OFS;
    assign wr_imask = wr_go && awaddr_q == RUCC_IMASK_OFS;
    assign wr_hit   = wr_ctrl || wr_wdog || wr_cmd || wr_imask;
    assign cmd_w    = merge(32'h0, wdata_q, wstrb_q);

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_q          <= 1'b0;
            w_q           <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h0;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RUCC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_q && !s_axi_awready;
            s_axi_wready  <= !w_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q          <= 1'b1;
                awaddr_q      <= {s_axi_awaddr[7:2], 2'b00};
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q          <= 1'b1;
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RUCC_RESP_OKAY : RUCC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_q         <= 1'b0;
                w_q          <= 1'b0;
            end
        end
    end

    // Factory-only setup writes; ignored while an application runs
    logic setup_ok;
    assign setup_ok = factory_active && st_q == RUCC_ST_USER;
    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= RUCC_CTRL_RST;
            wdog_q <= RUCC_WDOG_RST;
        end else if (setup_ok) begin
            if (wr_ctrl) begin
                ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
            end
            if (wr_wdog) begin
                wdog_q <= merge(wdog_q, wdata_q, wstrb_q);
            end
        end
    end

    // Events
    logic kick, recfg, wd_fire, ld_done, ld_err, ld_tmo;
    logic arm_q;
    assign kick    = wr_cmd && cmd_w[RUCC_CMD_KICK_BIT];
    assign recfg   = wr_cmd && cmd_w[RUCC_CMD_RECFG_BIT];
    assign ld_done = st_q == RUCC_ST_LOAD && arm_q && done_s[1] && !err_s[1];
    assign ld_tmo  = st_q == RUCC_ST_LOAD && tmo_q == 32'h0;
    assign ld_err  = st_q == RUCC_ST_LOAD && ((arm_q && err_s[1]) || ld_tmo);
    assign wd_fire = st_q == RUCC_ST_USER && !factory_active
                     && app_rupd_q && wcnt_q == 32'h0;

    // Result levels of the previous load linger through the synchroniser,
    // so a result counts only after both were seen low in this load
    always_ff @(posedge clock) begin
        if (rst || st_q != RUCC_ST_LOAD || ld_done || ld_err) begin
            arm_q <= 1'b0;
        end else if (!done_s[1] && !err_s[1]) begin
            arm_q <= 1'b1;
        end
    end

    // Load sequencer
    logic [2:0] next_pg;
    assign next_pg = ctrl_q[RUCC_CTRL_PAGE_LSB +: 3];
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q           <= RUCC_ST_BOOT;
            loc_q          <= 1'b0;
            load_start     <= 1'b0;
            load_page      <= RUCC_FACTORY_PAGE;
            load_scheme    <= RUCC_SCH_SERIAL;
            factory_active <= 1'b1;
            user_mode      <= 1'b0;
            app_rupd_q     <= 1'b0;
            tmo_q          <= 32'h0;
        end else begin
            load_start <= 1'b0;
            if (st_q == RUCC_ST_LOAD && tmo_q != 32'h0) tmo_q <= tmo_q - 32'h1;
            unique case (st_q)
                RUCC_ST_BOOT: begin
                    loc_q          <= mode_s[1];
                    st_q           <= RUCC_ST_LOAD;
                    load_start     <= 1'b1;
                    tmo_q          <= LOAD_TMO;
                    factory_active <= !mode_s[1];
                    // Local boot picks the single app page, remote boots 000
                    load_page      <= mode_s[1] ? 3'h1
                                                : RUCC_FACTORY_PAGE;
                end
                RUCC_ST_LOAD: begin
                    if (ld_err) begin
                        st_q           <= RUCC_ST_LOAD;
                        load_start     <= 1'b1;
                        tmo_q          <= LOAD_TMO;
                        load_page      <= RUCC_FACTORY_PAGE;
                        factory_active <= 1'b1;
                    end else if (ld_done) begin
                        st_q      <= RUCC_ST_USER;
                        user_mode <= 1'b1;
                        app_rupd_q <= !factory_active && !loc_q;
                    end
                end
                RUCC_ST_USER: begin
                    if (wd_fire || (recfg && !factory_active)) begin
                        // Return to factory on timeout or app request
                        st_q           <= RUCC_ST_LOAD;
                        user_mode      <= 1'b0;
                        load_start     <= 1'b1;
                        tmo_q          <= LOAD_TMO;
                        load_page      <= RUCC_FACTORY_PAGE;
                        factory_active <= 1'b1;
                        app_rupd_q     <= 1'b0;
                    end else if (recfg && next_pg != RUCC_FACTORY_PAGE) begin
                        // Page 000 can never be the application target
                        st_q           <= RUCC_ST_LOAD;
                        user_mode      <= 1'b0;
                        load_start     <= 1'b1;
                        tmo_q          <= LOAD_TMO;
                        load_page      <= next_pg;
                        load_scheme    <= ctrl_q[RUCC_CTRL_SCH_LSB +: 2];
                        factory_active <= 1'b0;
                    end
                end
                default: st_q <= RUCC_ST_BOOT;
            endcase
        end
    end

    // User watchdog; held off whenever the factory image is running
    always_ff @(posedge clock) begin
        if (rst || factory_active || !ctrl_q[RUCC_CTRL_WDEN_BIT]) begin
            wcnt_q <= 32'hffff_ffff;
        end else if (st_q != RUCC_ST_USER) begin
            wcnt_q <= wdog_q;
        end else if (kick && app_rupd_q) begin
            wcnt_q <= wdog_q;
        end else if (wcnt_q != 32'h0) begin
            wcnt_q <= wcnt_q - 32'h1;
        end
    end

    // Read path
    logic rd_cause, rd_istat;
    logic [31:0] rd_val;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        rd_val = 32'h0;
        unique case ({s_axi_araddr[7:2], 2'b00})
            RUCC_CTRL_OFS:  rd_val = ctrl_q;
            RUCC_WDOG_OFS:  rd_val = wdog_q;
            RUCC_CMD_OFS:   rd_val = 32'h0;
            RUCC_STATE_OFS: rd_val = {26'h0, loc_q, user_mode,
                                      factory_active, load_page};
            RUCC_CAUSE_OFS: rd_val = {30'h0, cause_q};
            RUCC_ISTAT_OFS: rd_val = {29'h0, istat_q};
            RUCC_IMASK_OFS: rd_val = {29'h0, imask_q};
            default:        rd_ok  = 1'b0;
        endcase
    end
    assign rd_cause = s_axi_arvalid && s_axi_arready
                      && {s_axi_araddr[7:2], 2'b00} == RUCC_CAUSE_OFS;
    assign rd_istat = s_axi_arvalid && s_axi_arready
                      && {s_axi_araddr[7:2], 2'b00} == RUCC_ISTAT_OFS;

    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RUCC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_val;
                s_axi_rresp   <= rd_ok ? RUCC_RESP_OKAY : RUCC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Cause code: a new event wins over the read clear
    always_ff @(posedge clock) begin
        if (rst) begin
            cause_q <= RUCC_CAUSE_NONE;
        end else if (wd_fire) begin
            cause_q <= RUCC_CAUSE_WDOG;
        end else if (ld_err && !factory_active) begin
            cause_q <= RUCC_CAUSE_LERR;
        end else if (st_q == RUCC_ST_USER && recfg && !factory_active) begin
            cause_q <= RUCC_CAUSE_USER;
        end else if (rd_cause && factory_active) begin
            cause_q <= RUCC_CAUSE_NONE;
        end
    end

    // Sticky interrupt status, cleared by read, set wins
    logic [RUCC_IRQ_N-1:0] ev;
    assign ev = {ld_done, ld_err && !factory_active, wd_fire};
    always_ff @(posedge clock) begin
        if (rst) begin
            istat_q <= '0;
            imask_q <= '0;
            irq     <= 1'b0;
        end else begin
            istat_q <= (rd_istat ? '0 : istat_q) | ev;
            if (wr_imask) imask_q <= wdata_q[RUCC_IRQ_N-1:0];
            irq <= |(((rd_istat ? '0 : istat_q) | ev) & imask_q);
        end
    end
endmodule

// *** rucc_cfg_mem.sv ***
// Behavioural paged configuration memory answering load requests
module rucc_cfg_mem (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Load request from the controller
    input  wire logic       load_start,
    input  wire logic [2:0] load_page,
    // Bench controls: corrupted pages and answer delay
    input  wire logic [7:0] bad_mask,
    input  wire logic [7:0] dly,
    // Result levels, held until the next request
    output logic            load_done_pin,
    output logic            load_err_pin
);
    logic [7:0] cnt_q;
    logic [2:0] pg_q;
    logic       busy_q;
    logic       bad;

    // Factory page is never corrupted, as it is never updated remotely
    assign bad = bad_mask[pg_q] && pg_q != 3'h0;

    always_ff @(posedge clock) begin
        if (rst || load_start) begin
            load_done_pin <= 1'b0;
            load_err_pin  <= 1'b0;
            busy_q        <= !rst;
            cnt_q         <= dly;
            pg_q          <= load_page;
        end else if (busy_q) begin
            if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end else begin
                busy_q        <= 1'b0;
                load_err_pin  <= bad;
                load_done_pin <= !bad;
            end
        end
    end
endmodule

// *** rucc_asserts.sv ***
// Checker for boot, fallback and load-flag relations of rucc_ctrl
module rucc_asserts #(
    parameter int unsigned LOAD_TMO = 50
) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       rst,
    // Configuration memory side
    input wire logic       local_mode_pin,
    input wire logic       load_done_pin,
    input wire logic       load_err_pin,
    input wire logic       load_start,
    input wire logic [2:0] load_page,
    input wire logic [1:0] load_scheme,
    // Status
    input wire logic       user_mode,
    input wire logic       factory_active
);
    // Silent memory is cut off by the load timeout, plus sync slack
    localparam int TMO_B = LOAD_TMO + 12;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_boot_remote: assert property (
        $fell(rst) && !local_mode_pin |-> ##[0:3]
        (load_start && load_page == 3'h0)) else $error("no factory boot");
    a_boot_local: assert property (
        $fell(rst) && local_mode_pin |-> ##[0:3]
        (load_start && load_page == 3'h1)) else $error("no local boot");
    a_err_fallback: assert property (
        $rose(load_err_pin) && !factory_active |-> ##[1:8]
        (load_start && load_page == 3'h0)) else $error("no fallback");
    a_app_settles: assert property (
        load_start && load_page != 3'h0 |=> ##[1:TMO_B]
        (user_mode || (load_start && load_page == 3'h0)))
        else $error("app load unresolved");
    a_user_on_done: assert property (
        $rose(user_mode) |-> load_done_pin && !load_err_pin)
        else $error("user mode without clean load");
    a_start_quits: assert property (
        load_start |=> !user_mode) else $error("user mode during load");
    a_factory_flag: assert property (
        load_start && load_page == 3'h0 |-> ##[0:1] factory_active)
        else $error("factory flag low");
    a_app_flag: assert property (
        load_start && load_page != 3'h0 |-> ##[0:1] !factory_active)
        else $error("factory flag high");
    a_scheme_legal: assert property (
        load_scheme != 2'h3) else $error("bad scheme");
endmodule

bind rucc_ctrl rucc_asserts #(.LOAD_TMO(LOAD_TMO)) rucc_asserts_inst (
    .clock, .rst, .local_mode_pin, .load_done_pin, .load_err_pin,
    .load_start, .load_page, .load_scheme, .user_mode, .factory_active
);

// *** rucc_ctrl_tb.sv ***
// Self-checking bench for rucc_ctrl: boot, page select, watchdog, faults
module rucc_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rucc_pkg::*;
    localparam int TMO = 50;
    logic        clock, rst, local_mode_pin;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, bad_mask, dly;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, load_start;
    logic [1:0]  s_axi_bresp, s_axi_rresp, load_scheme, rsp;
    logic        load_done_pin, load_err_pin, user_mode, factory_active, irq;
    logic [2:0]  load_page;
    logic [31:0] seed = 32'h0000_2229;
    int          n_fail = 0;
    int          num_checks = 0;
    int          wt, sch;

    rucc_ctrl #(.LOAD_TMO(TMO)) rucc_ctrl_inst (
        .clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .local_mode_pin, .load_done_pin,
        .load_err_pin, .load_start, .load_page, .load_scheme,
        .user_mode, .factory_active, .irq);
    rucc_cfg_mem rucc_cfg_mem_inst (.clock, .rst, .load_start, .load_page,
        .bad_mask, .dly, .load_done_pin, .load_err_pin);

    function automatic logic [31:0] xs(logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] st_exp(logic u, f, logic [2:0] pg);
        return {26'h0, 1'b0, u, f, pg};
    endfunction

    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    // Bus tasks start on a fresh edge so no strobe is set twice at once
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask
    task automatic axr(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask
    task automatic wait_lvl(input logic v);
        int k;
        k = 0;
        while (user_mode !== v && k < 4000) begin
            @(posedge clock);
            k++;
        end
        chk("wait user_mode", 32'(k < 4000), 1);
    endtask
    task automatic reload();
        wait_lvl(1'b0);
        wait_lvl(1'b1);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Whole run needs well under 20k cycles
    initial begin
        repeat (30000) @(posedge clock);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        {rst, local_mode_pin, s_axi_awvalid, s_axi_wvalid} = 4'h8;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        bad_mask = 8'h00;
        dly = 8'h04;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        wait_lvl(1'b1);
        chk("boot page", load_page, 0);
        axr(RUCC_STATE_OFS);
        chk("state", rd, st_exp(1, 1, 3'h0));
        axr(8'h1c);
        chk("unmapped", rsp, RUCC_RESP_SLVERR);
        axw(8'h1c, 32'h0);
        chk("wr unmapped", rsp, RUCC_RESP_SLVERR);
        axw(RUCC_IMASK_OFS, 32'h2);
        chk("wr resp", rsp, RUCC_RESP_OKAY);
        for (int p = 1; p <= 7; p++) begin
            seed = xs(seed);
            sch = seed % 3;
            dly <= 8'(3 + seed[12:8]);
            axw(RUCC_CTRL_OFS, 32'(p) | (32'(sch) << 8));
            axw(RUCC_CMD_OFS, 32'h1);
            reload();
            chk("page", load_page, 32'(p));
            chk("scheme", load_scheme, 32'(sch));
            axr(RUCC_STATE_OFS);
            chk("state", rd, st_exp(1, 0, 3'(p)));
            // Application asks for the factory image after an update
            axw(RUCC_CMD_OFS, 32'h1);
            reload();
            axr(RUCC_CAUSE_OFS);
            chk("cause", rd, 32'(RUCC_CAUSE_USER));
        end
        seed = xs(seed);
        wt = 40 + seed % 40;
        axw(RUCC_WDOG_OFS, 32'(wt));
        axw(RUCC_CTRL_OFS, 32'h13);
        axw(RUCC_CMD_OFS, 32'h1);
        reload();
        repeat (6) begin
            repeat (wt / 4) @(posedge clock);
            axw(RUCC_CMD_OFS, 32'h2);
        end
        chk("kept alive", user_mode, 1);
        chk("app page", load_page, 3);
        reload();
        chk("wd fallback", factory_active, 1);
        axr(RUCC_CAUSE_OFS);
        chk("wd cause", rd, 32'(RUCC_CAUSE_WDOG));
        axr(RUCC_CAUSE_OFS);
        chk("cause cleared", rd, 32'(RUCC_CAUSE_NONE));
        chk("masked irq", irq, 0);
        // Page 0 is refused; factory has no watchdog running
        axw(RUCC_CTRL_OFS, 32'h10);
        axw(RUCC_CMD_OFS, 32'h1);
        repeat (2 * wt) @(posedge clock);
        chk("no reload", user_mode, 1);
        chk("still factory", load_page, 0);
        bad_mask <= 8'h20;
        axw(RUCC_CTRL_OFS, 32'h5);
        axw(RUCC_CMD_OFS, 32'h1);
        reload();
        chk("err page", load_page, 0);
        chk("err irq", irq, 1);
        axr(RUCC_CAUSE_OFS);
        chk("err cause", rd, 32'(RUCC_CAUSE_LERR));
        axr(RUCC_ISTAT_OFS);
        chk("istat", rd & 32'h2, 32'h2);
        repeat (2) @(posedge clock);
        chk("irq cleared", irq, 0);
        local_mode_pin <= 1'b1;
        rst <= 1'b1;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        wait_lvl(1'b1);
        chk("local page", load_page, 1);
        chk("local app", factory_active, 0);
        tally_and_finish();
    end
endmodule
